/* File: include/status_id_pkg.sv */
// Constants and types for the status and identifier register bank
package status_id_pkg;
   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [4:0] basic_status_addr = 5'h01;
   localparam logic [4:0] identifier_high_addr = 5'h02;
   localparam logic [4:0] identifier_low_addr = 5'h03;
   // ***************************************************************
   // Field positions of the basic status register
   // ***************************************************************
   localparam int ext_cap_pos = 0;
   localparam int jabber_pos = 1;
   localparam int link_pos = 2;
   localparam int rfault_pos = 4;
   // Fixed capability bits 15:11 and 3 (5'b01111 and 1)
   localparam logic [4:0] speed_caps_val = 5'h0f;
   localparam logic aneg_ability_val = 1'b1;
   localparam logic ext_cap_val = 1'b1;
   // ***************************************************************
   // Identifier field positions
   // ***************************************************************
   localparam int org_lo_msb = 15;
   localparam int org_lo_lsb = 10;
   localparam int model_msb = 9;
   localparam int model_lsb = 4;
   localparam int rev_msb = 3;
   // Reset values of the latched bits
   localparam logic link_rst = 1'b0;
   localparam logic jabber_rst = 1'b0;
   localparam logic rfault_rst = 1'b0;
   typedef logic [15:0] reg16_t;
endpackage : status_id_pkg

/* File: include/latch_if.sv */
// Interface carrying raw conditions and read strobe to the latch bank
`timescale 1ns/1ns
interface latch_if;
   logic link_ok; // Current link valid
   logic jabber; // Jabber condition seen
   logic rfault; // Partner remote fault
   logic clear; // Status register read this cycle
   logic link_l; // Latched link bit
   logic jabber_l; // Latched jabber bit
   logic rfault_l; // Latched remote fault bit
   modport bank (input link_ok, jabber, rfault, clear, output link_l, jabber_l, rfault_l);
   modport user (output link_ok, jabber, rfault, clear, input link_l, jabber_l, rfault_l);
endinterface : latch_if

/* File: logic/status_latches.sv */
// Latch-low link bit and latch-high jabber and remote fault bits
`timescale 1ns/1ns
module status_latches (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clk_en,
   latch_if.bank lif
);
   import status_id_pkg::*;
   // ***************************************************************
   // Latches
   // ***************************************************************
   // Link: a failure wins over the read clear, so a drop is never missed
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         lif.link_l <= link_rst;
      end else if (clk_en) begin
         if (!lif.link_ok) begin
            lif.link_l <= 1'b0;
         end else if (lif.clear || lif.link_l) begin
            lif.link_l <= 1'b1;
         end else begin
            lif.link_l <= 1'b0;
         end
      end
   end
   // Jabber: set wins over clear
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         lif.jabber_l <= jabber_rst;
      end else if (clk_en) begin
         if (lif.jabber) begin
            lif.jabber_l <= 1'b1;
         end else if (lif.clear) begin
            lif.jabber_l <= 1'b0;
         end
      end
   end
   // Remote fault: set wins over clear
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         lif.rfault_l <= rfault_rst;
      end else if (clk_en) begin
         if (lif.rfault) begin
            lif.rfault_l <= 1'b1;
         end else if (lif.clear) begin
            lif.rfault_l <= 1'b0;
         end
      end
   end
   // ***************************************************************
   // Checks
   // ***************************************************************
   a_link_drop_held: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clk_en && !lif.link_ok) |=> !lif.link_l)
      else $error("link bit not cleared by failure");
   a_link_stays_low: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clk_en && !lif.link_l && !lif.clear) |=> !lif.link_l)
      else $error("link bit rose without a read");
   a_jabber_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clk_en && lif.jabber) |=> lif.jabber_l)
      else $error("jabber not latched");
   a_jabber_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clk_en && lif.jabber_l && !lif.clear) |=> lif.jabber_l)
      else $error("jabber dropped without read");
   a_rfault_latch: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clk_en && (lif.rfault || (lif.rfault_l && !lif.clear))) |=> lif.rfault_l)
      else $error("remote fault not held");
   a_read_rearm: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clk_en && lif.clear && lif.link_ok && !lif.jabber) |=> (lif.link_l && !lif.jabber_l))
      else $error("latches not rearmed by read");
   // Clock enable low holds the jabber latch even with jabber present
   a_jabber_frozen: assert property (@(posedge sys_clk) disable iff (!nrst)
      (!clk_en) |=> $stable(lif.jabber_l))
      else $error("jabber latch moved while frozen");
endmodule : status_latches

/* File: logic/status_id_regs.sv */
// Read-only status and identifier register bank, management clock domain
`timescale 1ns/1ns
module status_id_regs #(
   parameter logic [21:0] org_id = 22'h000000, // Org id bits 3..24; arbitrary value
   parameter logic [5:0] model_number = 6'h00, // Arbitrary value
   parameter logic [3:0] model_revision = 4'h0, // Arbitrary value
   parameter bit id_zero = 1'b0 // Return all-zero identifier
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic [4:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic link_ok,
   input wire logic jabber,
   input wire logic speed_10,
   input wire logic partner_rfault,
   output status_id_pkg::reg16_t reg_rdata
);
   import status_id_pkg::*;
   // ***************************************************************
   // Latch bank
   // ***************************************************************
   latch_if lif ();
   reg16_t rdata_d; // Next read data
   logic [15:0] id_high; // High identifier word
   logic [15:0] id_low; // Low identifier word
   // Writes are accepted but nothing here is writable
   logic unused_wr;
   assign unused_wr = reg_wr ^ (^reg_wdata);
   assign lif.link_ok = link_ok;
   // Jabber only counts in 10 Mb/s; at 100 the indication is not meaningful
   assign lif.jabber = jabber & speed_10;
   assign lif.rfault = partner_rfault;
   assign lif.clear = reg_rd && (reg_addr == basic_status_addr);
   status_latches u_latches (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .lif(lif)
   );
   // ***************************************************************
   // Identifier words
   // ***************************************************************
   // Top two org id bits never stored; high word is org bits 3..18
   assign id_high = id_zero ? 16'h0000 : org_id[21:6];
   assign id_low = id_zero ? 16'h0000 : {org_id[5:0], model_number, model_revision};
   // ***************************************************************
   // Read mux
   // ***************************************************************
   always_comb begin
      rdata_d = 16'h0000;
      case (reg_addr)
         basic_status_addr: begin
            rdata_d[15:11] = speed_caps_val;
            rdata_d[3] = aneg_ability_val;
            rdata_d[rfault_pos] = lif.rfault_l;
            rdata_d[link_pos] = lif.link_l;
            rdata_d[jabber_pos] = lif.jabber_l;
            rdata_d[ext_cap_pos] = ext_cap_val;
         end
         identifier_high_addr: begin
            rdata_d = id_high;
         end
         identifier_low_addr: begin
            rdata_d = id_low;
         end
         default: begin
            rdata_d = 16'h0000;
         end
      endcase
   end
   // Read data captured on the read strobe, so the value seen is pre-clear
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 16'h0000;
      end else if (clk_en && reg_rd) begin
         reg_rdata <= rdata_d;
      end
   end
   a_ext_cap_one: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clk_en && reg_rd && reg_addr == basic_status_addr) |=> reg_rdata[0])
      else $error("extended capability bit not one");
   a_id_low_map: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clk_en && reg_rd && reg_addr == identifier_low_addr && !id_zero)
      |=> reg_rdata[9:4] == model_number)
      else $error("model number misplaced");
   // Zero identifier option must blank the high identifier word
   a_id_zero_high: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clk_en && reg_rd && reg_addr == identifier_high_addr && id_zero)
      |=> reg_rdata == 16'h0000)
      else $error("identifier not zero");
   // High word carries org id bits 3..18 in order
   a_id_high_map: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clk_en && reg_rd && reg_addr == identifier_high_addr && !id_zero)
      |=> reg_rdata == org_id[21:6])
      else $error("high identifier misplaced");
   // A low enable freezes the read data even under a read strobe
   a_rdata_frozen: assert property (@(posedge sys_clk) disable iff (!nrst)
      (!clk_en) |=> $stable(reg_rdata))
      else $error("read data moved while frozen");
endmodule : status_id_regs

/* File: tb/line_side_model.sv */
// Line-side model giving link, jabber, speed and partner fault levels
`timescale 1ns/1ns
module line_side_model (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [3:0] want,
   output logic link_ok,
   output logic jabber,
   output logic partner_rfault,
   output logic speed_10
);
   // Registered like a real detector, so levels move just after an edge
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         {link_ok, jabber, partner_rfault, speed_10} <= 4'h0;
      end else begin
         {link_ok, jabber, partner_rfault, speed_10} <= want;
      end
   end
endmodule : line_side_model

/* File: tb/tb.sv */
// Self-checking bench for the status and identifier register bank
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
   import status_id_pkg::*;
   localparam logic [21:0] org_v = 22'h2a5c3b; // Arbitrary value
   localparam logic [5:0] mdl_v = 6'h2d; // Arbitrary value
   localparam logic [3:0] rev_v = 4'h9; // Arbitrary value
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic clk_en = 1'b1;
   logic [4:0] reg_addr = 5'h00;
   logic reg_rd = 1'b0;
   logic reg_wr = 1'b0;
   logic [15:0] reg_wdata = 16'h0000;
   logic [3:0] want = 4'h9; // Link up, 10 Mb/s
   logic link_ok, jabber, partner_rfault, speed_10;
   reg16_t reg_rdata;
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #50 sys_clk = ~sys_clk;
   line_side_model line_side_model_i (.sys_clk(sys_clk), .nrst(nrst), .want(want),
      .link_ok(link_ok), .jabber(jabber), .partner_rfault(partner_rfault), .speed_10(speed_10));
   status_id_regs #(.org_id(org_v), .model_number(mdl_v), .model_revision(rev_v))
   status_id_regs_i (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .link_ok(link_ok),
      .jabber(jabber), .speed_10(speed_10), .partner_rfault(partner_rfault),
      .reg_rdata(reg_rdata));
   // Expected status word from fault, link and jabber bits
   function automatic reg16_t st(logic rf, logic lk, logic jb);
      return {5'h0f, 6'h00, rf, 1'b1, lk, jb, 1'b1};
   endfunction : st
   // One-cycle read strobe; data lands on the edge that takes it
   task automatic rd(logic [4:0] a, reg16_t e, string n);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 `CHK(n, e, reg_rdata)
   endtask : rd
   // Write strobe, which the bank must ignore
   task automatic wr(logic [4:0] a, logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Line conditions {link, jabber, fault, 10M}; three edges let the latches settle
   task automatic cond(logic [3:0] w);
      @(posedge sys_clk);
      want <= w;
      repeat (3) @(posedge sys_clk);
   endtask : cond
   task automatic finish_test();
      if (errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test
   // Hang guard, far above the roughly 120 cycles the sequence needs
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         errors++;
         finish_test();
      end
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(basic_status_addr, st(0, 0, 0), "rst");
      rd(basic_status_addr, st(0, 1, 0), "up");
      cond(4'h1);
      cond(4'h9);
      rd(basic_status_addr, st(0, 0, 0), "drop");
      rd(basic_status_addr, st(0, 1, 0), "rearm");
      cond(4'hd);
      cond(4'h9);
      rd(basic_status_addr, st(0, 1, 1), "jab");
      rd(basic_status_addr, st(0, 1, 0), "jabclr");
      cond(4'hc);
      cond(4'h9);
      rd(basic_status_addr, st(0, 1, 0), "jab100");
      cond(4'hb);
      cond(4'h9);
      rd(basic_status_addr, st(1, 1, 0), "rf");
      rd(basic_status_addr, st(0, 1, 0), "rfclr");
      cond(4'hd);
      cond(4'h9);
      @(posedge sys_clk);
      nrst <= 1'b0;
      @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(basic_status_addr, st(0, 0, 0), "jabrst");
      wr(basic_status_addr, 16'h0000);
      rd(basic_status_addr, st(0, 1, 0), "ext");
      rd(identifier_high_addr, org_v[21:6], "idh");
      rd(identifier_low_addr, {org_v[5:0], mdl_v, rev_v}, "idl");
      wr(identifier_low_addr, 16'hffff);
      rd(identifier_low_addr, {org_v[5:0], mdl_v, rev_v}, "idlw");
      rd(5'h1f, 16'h0000, "unmap");
      // Frozen bank: no capture, no latching while the enable is low
      @(posedge sys_clk);
      clk_en <= 1'b0;
      cond(4'hd);
      rd(basic_status_addr, 16'h0000, "frz");
      cond(4'h9);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      rd(basic_status_addr, st(0, 1, 0), "thaw");
      finish_test();
   end
endmodule : tb
